// ---- hdl/ebg_bus_grant.v ----
`timescale 1ns/1ps
// Contract
// RQ1: A request seen at a processor-cycle boundary is taken in that cycle, otherwise in the next.
// RQ2: The grant goes low in the processor cycle after the one in which the request was taken.
// RQ3: The request may be asynchronous and is synchronised inside the block.
// RQ4: On surrender the five selects and strobes float, starting at a rising clock-out edge.
// RQ5: The grant goes low only after all five outputs have floated.
// RQ6: The outputs are driven again only once the grant has returned high.
// RQ7: The outputs are driven before the clock-out rising edge at which bus activity resumes.
// RQ8: The grant stays low while the request persists and is released when it is withdrawn.
`include "ebg_regs.vh"

module ebg_bus_grant (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst_n,
    // Bus arbitration pins
    input  wire       bus_request_n,
    output reg        bus_grant_n,
    // Core strobes (active low): dms, pms, bms, rd, wr
    input  wire [4:0] core_strobe_n,
    // Memory select and strobe pins, enable low = driving
    output reg        data_mem_select_n,
    output reg        prog_mem_select_n,
    output reg        boot_mem_select_n,
    output reg        read_strobe_n,
    output reg        store_strobe_n,
    output reg        strobe_oe_n,
    // Clock out and core status
    output reg        processor_clock_out,
    output reg        core_hold
);

// =============================================
// Request synchroniser
wire req_sync_n;

ebg_sync u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (bus_request_n),
    .sync_out (req_sync_n)
); // RQ3

// =============================================
// Clock-out phase and arbitration
reg [2:0] state;
reg [2:0] next_state;
reg       next_grant_n;
reg       next_oe_n;
reg       next_hold;

// Rising edge of clock-out begins each processor cycle
wire cyc_start = (processor_clock_out == `EBG_PHASE_LOW);

always @* begin
    next_state   = state;
    next_grant_n = bus_grant_n;
    next_oe_n    = strobe_oe_n;
    next_hold    = core_hold;
    case (state)
        `EBG_ST_OWN: begin
            // Sampled once per processor cycle; late arrival waits one cycle
            if (cyc_start && !req_sync_n) begin // RQ1
                next_state = `EBG_ST_RELEASE;
                next_hold  = 1'b1;
                next_oe_n  = 1'b1; // RQ4
            end
        end
        `EBG_ST_RELEASE: begin
            // Grant follows at the next cycle, after outputs have floated
            if (cyc_start) begin
                next_state   = `EBG_ST_GRANT;
                next_grant_n = 1'b0; // RQ2 RQ5
            end
        end
        `EBG_ST_GRANT: begin
            if (cyc_start && req_sync_n) begin // RQ8
                next_state   = `EBG_ST_REGAIN;
                next_grant_n = 1'b1;
            end
        end
        `EBG_ST_REGAIN: begin
            // Grant already high here, so enabling now never overlaps
            next_state = `EBG_ST_RESUME;
            next_oe_n  = 1'b0; // RQ6
        end
        `EBG_ST_RESUME: begin
            // Drivers on for at least a half cycle before activity resumes
            if (cyc_start) begin // RQ7
                next_state = `EBG_ST_OWN;
                next_hold  = 1'b0;
            end
        end
        default: begin
            next_state   = `EBG_ST_OWN;
            next_grant_n = 1'b1;
            next_oe_n    = 1'b0;
            next_hold    = 1'b0;
        end
    endcase
end

always @(posedge ref_clk) begin
    if (!rst_n) begin
        state               <= `EBG_ST_OWN;
        bus_grant_n         <= 1'b1;
        strobe_oe_n         <= 1'b0;
        core_hold           <= 1'b0;
        processor_clock_out <= `EBG_PHASE_LOW;
    end else begin
        state               <= next_state;
        bus_grant_n         <= next_grant_n;
        strobe_oe_n         <= next_oe_n;
        core_hold           <= next_hold;
        processor_clock_out <= ~processor_clock_out;
    end
end

// =============================================
// Strobe registers: idle while the bus is surrendered
always @(posedge ref_clk) begin
    if (!rst_n) begin
        {data_mem_select_n, prog_mem_select_n, boot_mem_select_n,
         read_strobe_n, store_strobe_n} <= `EBG_STROBE_IDLE;
    end else if (next_hold) begin
        {data_mem_select_n, prog_mem_select_n, boot_mem_select_n,
         read_strobe_n, store_strobe_n} <= `EBG_STROBE_IDLE; // RQ4
    end else begin
        {data_mem_select_n, prog_mem_select_n, boot_mem_select_n,
         read_strobe_n, store_strobe_n} <= core_strobe_n;
    end
end

endmodule

// ---- hdl/ebg_regs.vh ----
`ifndef EBG_REGS_VH
`define EBG_REGS_VH

// Processor cycle = two ref_clk periods (clock-out high half, low half)
`define EBG_PHASE_HIGH   1'b1
`define EBG_PHASE_LOW    1'b0

// Strobe idle level (active-low outputs inactive)
`define EBG_STROBE_IDLE  5'h1F
`define EBG_STROBE_W     5

// Arbiter state codes
`define EBG_ST_OWN       3'h0
`define EBG_ST_RELEASE   3'h1
`define EBG_ST_GRANT     3'h2
`define EBG_ST_REGAIN    3'h3
`define EBG_ST_RESUME    3'h4

`endif

// ---- hdl/ebg_sync.v ----
`timescale 1ns/1ps
// =============================================
// Two-stage synchroniser for an asynchronous level
module ebg_sync (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst_n,
    // Level in and out
    input  wire async_in,
    output reg  sync_out
);

reg meta;

always @(posedge ref_clk) begin
    if (!rst_n) begin
        meta     <= 1'b1;
        sync_out <= 1'b1;
    end else begin
        meta     <= async_in;
        sync_out <= meta;
    end
end

endmodule

// ---- testbench/ebg_bus_grant_tb.sv ----
`timescale 1ns/1ps
module ebg_bus_grant_tb;
    reg ref_clk = 1'b0, rst_n = 1'b0, want = 1'b0;
    reg [4:0] core_strobe_n = 5'h1F;
    reg [31:0] seed = 32'h00017586;
    reg [4:0] prev_strobe = 5'h1F;
    reg rst_q = 1'b0;
    integer cycles = 0;
    wire bus_request_n, bus_grant_n, strobe_oe_n, core_hold,
        data_mem_select_n, prog_mem_select_n, boot_mem_select_n,
        read_strobe_n, store_strobe_n, processor_clock_out;
    integer n_mismatch = 0, checked = 0, i, k;
    always #20 ref_clk = ~ref_clk;
    ebg_master pm (.*);
    ebg_bus_grant dut (.*);
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task check(input [4:0] seen, input [4:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t value mismatch", $time);
        end
    endtask
    task end_sim;
        $display("%0d checks %0d bad", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Bounded wait doubles as the hang guard
    task wait_gnt(input lvl);
        for (k = 0; k < 12 && bus_grant_n !== lvl; k = k + 1)
            @(negedge ref_clk);
        check(bus_grant_n, lvl);
    endtask
    always @(posedge ref_clk) begin
        seed = xs(seed);
        core_strobe_n <= seed[4:0];
        prev_strobe   <= core_strobe_n;
        rst_q         <= rst_n;
    end
    // Hang guard: about 40 loops of under two dozen cycles each
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles >= 5000) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    // Strobes follow the core, idle while the bus is away
    always @(negedge ref_clk) begin
        if (rst_q) begin
            check({data_mem_select_n, prog_mem_select_n, boot_mem_select_n,
                   read_strobe_n, store_strobe_n},
                  core_hold ? 5'h1F : prev_strobe);
            if (!bus_grant_n)
                check(strobe_oe_n, 5'h01);
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 40; i = i + 1) begin
            @(posedge ref_clk) want <= 1'b1;
            wait_gnt(1'b0);
            repeat (seed[2:0]) @(negedge ref_clk);
            @(posedge ref_clk) want <= 1'b0;
            wait_gnt(1'b1);
            $display("test %0d done", i);
        end
        end_sim;
    end
endmodule

// ---- testbench/ebg_master.sv ----
`timescale 1ns/1ps
module ebg_master (input wire ref_clk, want, bus_grant_n,
    output reg bus_request_n = 1'b1);
    // Asks anew only once the bus is back, so no request is lost
    always @(posedge ref_clk)
        if (want == bus_grant_n)
            bus_request_n <= !want;
endmodule

// ---- testbench/ebg_props.sv ----
`timescale 1ns/1ps
module ebg_props (input wire ref_clk, rst_n, bus_request_n, bus_grant_n,
    strobe_oe_n, core_hold, processor_clock_out);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_back; !strobe_oe_n ##[1:2] !core_hold; endsequence
    property p_take; !bus_request_n [*6] |-> strobe_oe_n; endproperty
    a_take: assert property (p_take) else $error("take");
    property p_gnt; $rose(strobe_oe_n) |-> ##2 !bus_grant_n; endproperty
    a_gnt: assert property (p_gnt) else $error("grant");
    property p_rq; $fell(bus_grant_n) |-> !$past(bus_request_n,3); endproperty
    a_rq: assert property (p_rq) else $error("cause");
    property p_edge; $rose(strobe_oe_n) |-> processor_clock_out; endproperty
    a_edge: assert property (p_edge) else $error("edge");
    property p_flt; $fell(bus_grant_n) |-> $past(strobe_oe_n,2); endproperty
    a_flt: assert property (p_flt) else $error("float");
    property p_held; !bus_grant_n |-> strobe_oe_n && core_hold; endproperty
    a_held: assert property (p_held) else $error("held");
    property p_back; $rose(bus_grant_n) |=> s_back; endproperty
    a_back: assert property (p_back) else $error("regain");
    property p_off; bus_request_n [*5] |-> bus_grant_n; endproperty
    a_off: assert property (p_off) else $error("stuck");
endmodule
bind ebg_bus_grant ebg_props chk (.*);
